// >>> core/iisl_core.sv
`timescale 1ns/1ps
module iisl_core (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [iisl_pkg::WORD_W-1:0] reg_first,
  input wire logic [iisl_pkg::WORD_W-1:0] reg_second,
  input wire logic [iisl_pkg::WORD_W-1:0] reg_third,
  input wire logic [iisl_pkg::WORD_W-1:0] mem_rdata,
  output logic [iisl_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [iisl_pkg::WORD_W-1:0] mem_wdata,
  output logic [iisl_pkg::ADDR_W-1:0] pc,
  output logic [iisl_pkg::ADDR_W-1:0] oper_addr,
  output logic oper_valid,
  output logic [iisl_pkg::WORD_W-1:0] instr,
  output logic busy
);
  import iisl_pkg::*;

  iisl_state_t state;
  iisl_state_t next_state;
  // Latches on start and holds until reset; there is no halt
  logic run;
  logic next_run;
  logic [ADDR_W-1:0] next_pc;
  logic [WORD_W-1:0] next_instr;
  // Second linkage address, carried from the store cycle into the load cycle
  logic [ADDR_W-1:0] eff;
  logic [ADDR_W-1:0] next_eff;
  logic [ADDR_W-1:0] next_oper_addr;
  logic next_oper_valid;
  logic [ADDR_W-1:0] direct_addr;
  logic [ADDR_W-1:0] indexed_addr;
  logic [ADDR_W-1:0] fld;
  logic [OP_W-1:0] op;
  logic pointer_unindexed;

  assign op = instr[OP_LSB +: OP_W];
  assign pointer_unindexed = instr[IND_BIT];
  assign fld = ADDR_W'(instr[FIELD_W-1:0]);
  assign busy = run;

  // Short field below 512 hits the common area, else stays in the current bank
  always_comb begin
    if (fld < COMMON_WORDS) begin
      direct_addr = fld; // see RQ13
    end else begin
      direct_addr = (pc & BANK_MASK) | fld;
    end
  end

  iisl_index_add #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) u_idx (
    .sel(mem_rdata[IDX_LSB +: IDX_W]), // see RQ1
    .base(mem_rdata[ADDR_W-1:0]), // see RQ3
    .reg_first(reg_first),
    .reg_second(reg_second),
    .reg_third(reg_third),
    .addr(indexed_addr)
  );

  always_comb begin
    next_state = state;
    next_run = run;
    next_pc = pc;
    next_instr = instr;
    next_eff = eff;
    next_oper_addr = oper_addr;
    next_oper_valid = 1'b0;
    mem_addr = pc;
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    mem_wdata = '0;
    case (state)
      ST_FETCH: begin
        if (start) begin
          next_run = 1'b1;
        end
        // Fetch on the start cycle too, so the first word is not lost
        if (run || start) begin
          mem_rd = 1'b1;
          next_instr = mem_rdata;
          next_pc = ADDR_W'(pc + 1'b1);
          if (mem_rdata[IND_BIT]) begin
            next_state = ST_PTR; // see RQ15
          end else if (mem_rdata[OP_LSB +: OP_W] == OP_CALL) begin
            next_state = ST_CALL_STORE; // see RQ4
          end else begin
            next_state = ST_OPER;
          end
        end
      end
      ST_PTR: begin
        // Address field names the pointer word
        mem_addr = direct_addr; // see RQ12
        mem_rd = 1'b1;
        if (op == OP_JUMP) begin
          // A jump through a linkage word lands on the saved return address
          next_pc = indexed_addr; // see RQ7
          next_state = ST_FETCH;
        end else begin
          next_oper_addr = indexed_addr; // see RQ3
          next_oper_valid = 1'b1;
          next_state = ST_FETCH;
        end
      end
      ST_CALL_STORE: begin
        // pc already holds the word after the call
        mem_addr = direct_addr;
        mem_wr = 1'b1;
        mem_wdata = WORD_W'(pc); // see RQ5
        next_eff = ADDR_W'(direct_addr + 1'b1);
        next_state = ST_CALL_LOAD;
      end
      ST_CALL_LOAD: begin
        // Target comes from the second linkage word
        mem_addr = eff;
        mem_rd = 1'b1;
        next_pc = mem_rdata[ADDR_W-1:0]; // see RQ6
        next_state = ST_FETCH; // see RQ8
      end
      ST_OPER: begin
        // Direct access: no indexing outside indirection
        if (op == OP_JUMP) begin
          next_pc = direct_addr;
        end else begin
          next_oper_addr = direct_addr; // see RQ3
          next_oper_valid = 1'b1;
        end
        next_state = ST_FETCH;
      end
      default: next_state = ST_FETCH;
    endcase
  end

  // Working registers are inputs only; linkage never touches them (see RQ9)
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_FETCH;
      run <= 1'b0;
      pc <= RESET_PC;
      instr <= '0;
      eff <= '0;
      oper_addr <= '0;
      oper_valid <= 1'b0;
    end else begin
      state <= next_state;
      run <= next_run;
      pc <= next_pc;
      instr <= next_instr;
      eff <= next_eff;
      oper_addr <= next_oper_addr;
      oper_valid <= next_oper_valid;
    end
  end

  // Call linkage: three word times, return address out, target in
  chk_call_three_words: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ4
    state == ST_CALL_STORE |=> state == ST_CALL_LOAD ##1 state == ST_FETCH)
    else $error("call did not take three word times");
  chk_call_store_link: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ5
    state == ST_CALL_STORE |-> mem_wr && mem_wdata == WORD_W'(pc))
    else $error("call did not store return address");
  chk_call_load_pc: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ6
    state == ST_CALL_LOAD |-> mem_addr == eff ##1 pc == ADDR_W'($past(mem_rdata)))
    else $error("call did not load target");
  chk_link_next_word: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ6
    state == ST_CALL_STORE |=> eff == ADDR_W'($past(mem_addr) + 1'b1))
    else $error("second linkage word not adjacent");
  chk_jump_return: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ7
    state == ST_PTR && op == OP_JUMP && mem_rdata[IDX_LSB +: IDX_W] == SEL_NONE
    |=> pc == ADDR_W'($past(mem_rdata)))
    else $error("indirect jump missed return address");
  chk_write_only_link: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ9
    mem_wr |-> state == ST_CALL_STORE)
    else $error("memory written outside call linkage");
  chk_jump_direct: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ3
    state == ST_OPER && op == OP_JUMP |=> pc == $past(direct_addr))
    else $error("direct jump target wrong");

  // Indexing, including wrap past the top of memory, then the common area and the pointer cycle
  chk_index_first: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ2
    state == ST_PTR && op != OP_JUMP && mem_rdata[IDX_LSB +: IDX_W] == SEL_FIRST
    |=> oper_valid && oper_addr == ADDR_W'($past(mem_rdata) + $past(reg_first)))
    else $error("first register indexing wrong");
  chk_index_second: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ2
    state == ST_PTR && op != OP_JUMP && mem_rdata[IDX_LSB +: IDX_W] == SEL_SECOND
    |=> oper_valid && oper_addr == ADDR_W'($past(mem_rdata) + $past(reg_second)))
    else $error("second register indexing wrong");
  chk_index_third_wrap: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ14
    state == ST_PTR && op != OP_JUMP && mem_rdata[IDX_LSB +: IDX_W] == SEL_THIRD
    |=> oper_valid && oper_addr == ADDR_W'($past(mem_rdata) + $past(reg_third)))
    else $error("third register indexing did not wrap");
  chk_no_index_direct: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ3
    state == ST_OPER && op != OP_JUMP |=> oper_addr == $past(direct_addr))
    else $error("direct access was indexed");
  chk_common_area: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ13
    state == ST_PTR && fld < COMMON_WORDS |-> mem_addr == fld)
    else $error("common area not reached directly");
  chk_ind_extra: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ15
    state == ST_FETCH && run && mem_rdata[IND_BIT] |=> state == ST_PTR && mem_rd)
    else $error("no pointer cycle for indirection");

  // Strobes and program counter per word time
  chk_fetch_advance: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ5
    state == ST_FETCH && mem_rd |=> pc == ADDR_W'($past(pc) + 1'b1) && state != ST_FETCH)
    else $error("fetch did not advance program counter");
  chk_strobe_exclusive: assert property (@(posedge core_clk) disable iff (!rst_n) // see RQ15
    !(mem_rd && mem_wr))
    else $error("read and write strobes together");

  // Scenarios worth seeing at least once
  cov_call: cover property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_CALL_STORE ##2 state == ST_FETCH);
  cov_return: cover property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_PTR && op == OP_JUMP);
  cov_indexed_third: cover property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_PTR && mem_rdata[IDX_LSB +: IDX_W] == SEL_THIRD);
  cov_indexed_second: cover property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_PTR && mem_rdata[IDX_LSB +: IDX_W] == SEL_SECOND);
  cov_jump_direct: cover property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_OPER && op == OP_JUMP);
endmodule

// >>> core/iisl_pkg.sv
// How it works
// RQ1: Pointer bits 16-17 pick the index register; zero means no indexing.
// RQ2: Codes one, two, three add the first, second or third working register.
// RQ3: Indexing applies only to indirect access, modifying the pointer's address.
// RQ4: The subroutine call takes exactly three word times including fetch.
// RQ5: First call cycle writes program counter plus one to the named location.
// RQ6: Second call cycle reads named location plus one into program counter.
// RQ7: Indirect jump through first linkage word resumes after the call.
// RQ8: Call plus return take five word times and two linkage words.
// RQ9: Calling leaves all three working registers untouched.
// RQ10: Software puts the first linkage word at an even address.
// RQ11: Software puts linkage where caller and subroutine both reach it.
// RQ12: Indirect access treats the address field as a pointer location.
// RQ13: The first 512 words are directly addressable from anywhere.
// RQ14: Base plus index wraps to the memory address width.
// RQ15: Indirect access spends one extra memory cycle fetching the pointer.
package iisl_pkg;
  localparam int WORD_W = 18;
  localparam int ADDR_W = 15;
  localparam int OP_W = 3;
  localparam int IDX_LSB = 16;
  localparam int IDX_W = 2;
  localparam int IND_BIT = 11;
  localparam int FIELD_W = 11;
  localparam int OP_LSB = 15;
  localparam logic [ADDR_W-1:0] COMMON_WORDS = 15'h0200;
  localparam logic [ADDR_W-1:0] BANK_MASK = 15'h7800;
  localparam logic [ADDR_W-1:0] RESET_PC = 15'h0000;
  localparam logic [OP_W-1:0] OP_CALL = 3'h0;
  localparam logic [OP_W-1:0] OP_JUMP = 3'h1;
  localparam logic [IDX_W-1:0] SEL_NONE = 2'h0;
  localparam logic [IDX_W-1:0] SEL_FIRST = 2'h1;
  localparam logic [IDX_W-1:0] SEL_SECOND = 2'h2;
  localparam logic [IDX_W-1:0] SEL_THIRD = 2'h3;
  typedef enum logic [2:0] {
    ST_FETCH, ST_PTR, ST_CALL_STORE, ST_CALL_LOAD, ST_OPER
  } iisl_state_t;
endpackage

// >>> core/iisl_index_add.sv
`timescale 1ns/1ps
module iisl_index_add #(
  parameter int ADDR_W = 15,
  parameter int WORD_W = 18
) (
  input wire logic [1:0] sel,
  input wire logic [ADDR_W-1:0] base,
  input wire logic [WORD_W-1:0] reg_first,
  input wire logic [WORD_W-1:0] reg_second,
  input wire logic [WORD_W-1:0] reg_third,
  output logic [ADDR_W-1:0] addr
);
  import iisl_pkg::*;
  // The base and the offset are cut from the word, so the address cannot be the wider one
  if (ADDR_W > WORD_W) begin : g_width_check
    $error("address wider than word");
  end
  logic [ADDR_W-1:0] offs;
  always_comb begin
    case (sel)
      SEL_FIRST: offs = reg_first[ADDR_W-1:0]; // see RQ2
      SEL_SECOND: offs = reg_second[ADDR_W-1:0]; // see RQ2
      SEL_THIRD: offs = reg_third[ADDR_W-1:0]; // see RQ2
      default: offs = '0; // see RQ1
    endcase
    // Carry out is dropped so indexed addresses wrap
    addr = ADDR_W'(base + offs); // see RQ14
  end
endmodule

// >>> tb/iisl_mem_model.sv
`timescale 1ns/1ps
module iisl_mem_model (
  input wire logic core_clk,
  input wire logic [iisl_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [iisl_pkg::WORD_W-1:0] mem_wdata,
  output logic [iisl_pkg::WORD_W-1:0] mem_rdata
);
  import iisl_pkg::*;
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  // Inverted data when not read, so a stray sample never matches by luck
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
  always @(posedge core_clk) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

// >>> tb/indirect_index_and_subroutine_link_bench.sv
`timescale 1ns/1ps
module indirect_index_and_subroutine_link_bench;
  import iisl_pkg::*;
  logic core_clk, rst_n, start, mem_rd, mem_wr, oper_valid, busy;
  logic [WORD_W-1:0] reg_first, reg_second, reg_third, mem_rdata, mem_wdata, instr;
  logic [ADDR_W-1:0] mem_addr, pc, oper_addr;
  int failures, n_checks;
  iisl_core iisl_core_i (.core_clk(core_clk), .rst_n(rst_n), .start(start),
    .reg_first(reg_first), .reg_second(reg_second), .reg_third(reg_third),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .pc(pc), .oper_addr(oper_addr), .oper_valid(oper_valid),
    .instr(instr), .busy(busy));
  iisl_mem_model iisl_mem_model_i (.core_clk(core_clk), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [WORD_W-1:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_call_return;
    check("reset pc", 18'h0, {3'h0, pc});
    check("idle busy", 18'h0, {17'h0, busy});
    start = 1'b1;
    // Strobes are combinational; let them settle before sampling
    #1;
    check("fetch rd", 18'h1, {17'h0, mem_rd});
    step;
    check("store wr", 18'h1, {17'h0, mem_wr});
    check("busy", 18'h1, {17'h0, busy});
    check("call instr", 18'h00100, instr);
    check("store addr", 18'h100, {3'h0, mem_addr});
    check("ret value", 18'h1, mem_wdata);
    step;
    check("target addr", 18'h101, {3'h0, mem_addr});
    step;
    check("call pc", 18'h40, {3'h0, pc});
    step;
    check("link read", 18'h100, {3'h0, mem_addr});
    step;
    check("return pc", 18'h1, {3'h0, pc});
    check("link word", 18'h1, iisl_mem_model_i.mem[15'h100]);
    check("link target", 18'h40, iisl_mem_model_i.mem[15'h101]);
    check("reg first", 18'h3, reg_first);
  endtask
  task automatic wait_oper(input logic [WORD_W-1:0] exp);
    int n;
    n = 0;
    do begin
      step;
      n++;
    end while (oper_valid !== 1'b1 && n < 6);
    check("oper valid", 18'h1, {17'h0, oper_valid});
    check("oper addr", exp, {3'h0, oper_addr});
  endtask
  task automatic t_indexed;
    step;
    check("ptr addr", 18'h120, {3'h0, mem_addr});
    wait_oper(18'h0010);
    wait_oper(18'h0555);
    wait_oper(18'h0103);
    wait_oper(18'h01F0);
    wait_oper(18'h0130);
  endtask
  task automatic t_direct_jump;
    step;
    step;
    check("jump pc", 18'h0600, {3'h0, pc});
  endtask
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    reg_first = 18'h00003;
    reg_second = 18'h00020;
    reg_third = 18'h3FFF0;
    failures = 0;
    n_checks = 0;
    for (int a = 0; a < 32768; a++) begin
      iisl_mem_model_i.mem[a] = 18'h3F000;
    end
    iisl_mem_model_i.mem[0] = 18'h00100;
    // Linkage pair even and in the common area
    iisl_mem_model_i.mem[15'h101] = 18'h00040;
    iisl_mem_model_i.mem[15'h40] = 18'h08900;
    for (int a = 0; a < 4; a++) begin
      iisl_mem_model_i.mem[a + 1] = 18'h10920 + 18'(a);
    end
    iisl_mem_model_i.mem[5] = 18'h10130;
    iisl_mem_model_i.mem[6] = 18'h08600;
    iisl_mem_model_i.mem[15'h120] = 18'h27FF0;
    iisl_mem_model_i.mem[15'h121] = 18'h00555;
    iisl_mem_model_i.mem[15'h122] = 18'h10100;
    iisl_mem_model_i.mem[15'h123] = 18'h30200;
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    step;
    t_call_return;
    t_indexed;
    t_direct_jump;
    summarize;
  end
  initial begin
    #(25 * 300);
    failures++;
    summarize;
  end
endmodule
